// file: scs_pkg.sv
// constants, field positions and carrier types for the serial channel setup block
// assumes a single 50 MHz clock and an AXI4-Lite register master
//
// Contract
// - gate bit 2 enables unit input clock
// - mode bit 15 picks prescaled clock a/b
// - mode bit 14 picks divider or pin clock
// - mode bits 2:1 protocol; 11 prohibited
// - mode bit 0: transfer end or buffer empty
// - divider field divides by 2*value+2
// - two control bits select direction enables
package scs_pkg;

    // ======================================================================
    // register byte addresses
    localparam logic [7:0] ADDR_CLOCK_GATE = 8'h00;
    localparam logic [7:0] ADDR_PRESCALER = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_COMM_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_DATA_DIV = 8'h10;
    localparam logic [7:0] ADDR_TX_DATA = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

    // ======================================================================
    // field positions
    localparam int GATE_SERIAL_BIT = 2;
    localparam int PRS_A_LSB = 0;
    localparam int PRS_B_LSB = 4;
    localparam int MODE_CLK_CHOICE_BIT = 15;
    localparam int MODE_CHANNEL_TRANSFER_CLOCK_SRC_BIT = 14;
    localparam int MODE_PROTO_LSB = 1;
    localparam int MODE_IRQ_SRC_BIT = 0;
    localparam int CTRL_TX_EN_BIT = 15;
    localparam int CTRL_RX_EN_BIT = 14;
    localparam int DIV_LSB = 9;
    localparam int IRQ_CHAN_BIT = 0;
    localparam int IRQ_PROHIB_BIT = 1;

    // ======================================================================
    // values after reset and codes
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [15:0] PRS_RESET = 16'h0000;
    localparam logic [15:0] MODE_RESET = 16'h0020;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam logic [1:0] PROTO_CSI = 2'h0;
    localparam logic [1:0] PROTO_UART = 2'h1;
    localparam logic [1:0] PROTO_TWO_WIRE = 2'h2;
    localparam logic [1:0] PROTO_PROHIBITED = 2'h3;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    localparam logic [3:0] DATA_BITS_LAST = 4'h7;

    // transmit sequencer, gray along idle-start-data-stop
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b11,
        TX_STOP = 2'b10
    } scs_tx_e;

    // complete registered state of the channel top
    typedef struct packed {
        logic [7:0] clock_gate;
        logic [15:0] prescaler;
        logic [15:0] mode;
        logic [15:0] comm_ctrl;
        logic [15:0] data_div;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] baud_cnt;
        logic [2:0] sck_sync;
        logic [7:0] tx_buf;
        logic tx_buf_full;
        logic [7:0] tx_shift;
        logic [3:0] bit_cnt;
        scs_tx_e tx_state;
        logic txd;
    } scs_state_s;

endpackage : scs_pkg

// file: scs_prescaler.sv
// two-output power-of-two prescaler producing one-cycle clock enables
// assumes the enable input is the unit's clock gate, on the same clock
`timescale 1ns/10ps
module scs_prescaler #(
    parameter int CNT_W = 15
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [3:0] sel_a,
    input wire logic [3:0] sel_b,
    output logic tick_a,
    output logic tick_b
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W:0] ones_ext;

    // ======================================================================
    // free counter, frozen while the unit clock is stopped
    always_comb begin
        cnt_d = cnt_q;
        if (run) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // a tick every 2^k cycles: the k low bits all ones; k=0 gives every cycle
    assign ones_ext = {1'b1, cnt_q};
    assign tick_a = run && (&(ones_ext | ~(((CNT_W+1)'(1) << sel_a) - (CNT_W+1)'(1))));
    assign tick_b = run && (&(ones_ext | ~(((CNT_W+1)'(1) << sel_b) - (CNT_W+1)'(1))));

endmodule : scs_prescaler

// file: scs_channel.sv
// serial unit channel 0: clock gate, prescaler choice, transfer clock and UART transmitter
// assumes an AXI4-Lite master on core_clk and an asynchronous serial clock pin
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module scs_channel (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_pin,
    output logic txd,
    output logic irq
);

    scs_pkg::scs_state_s q;
    scs_pkg::scs_state_s d;
    logic tick_a;
    logic tick_b;
    logic unit_run;
    logic op_tick;
    logic channel_transfer_clock_tick;
    logic [7:0] div_last;
    logic [1:0] proto;
    logic tx_enabled;
    logic [15:0] wr_word;
    logic [15:0] rd_word;
    logic [1:0] chan_event;
    logic rd_ok;

    // ======================================================================
    // clock gating and prescaler
    assign unit_run = q.clock_gate[scs_pkg::GATE_SERIAL_BIT];

    scs_prescaler #(
        .CNT_W(15)
    ) u_prescaler (
        .core_clk(core_clk),
        .srst(srst),
        .run(unit_run),
        .sel_a(q.prescaler[scs_pkg::PRS_A_LSB +: 4]),
        .sel_b(q.prescaler[scs_pkg::PRS_B_LSB +: 4]),
        .tick_a(tick_a),
        .tick_b(tick_b)
    );

    // operation clock choice, then divider or pin edge as transfer clock
    assign op_tick = q.mode[scs_pkg::MODE_CLK_CHOICE_BIT] ? tick_b : tick_a;
    assign div_last = {q.data_div[scs_pkg::DIV_LSB +: 7], 1'b1};
    always_comb begin
        channel_transfer_clock_tick = 1'b0;
        if (unit_run) begin
            if (q.mode[scs_pkg::MODE_CHANNEL_TRANSFER_CLOCK_SRC_BIT]) begin
                channel_transfer_clock_tick = q.sck_sync[1] && !q.sck_sync[2];
            end else begin
                channel_transfer_clock_tick = op_tick && (q.baud_cnt >= div_last);
            end
        end
    end

    assign proto = q.mode[scs_pkg::MODE_PROTO_LSB +: 2];
    assign tx_enabled = q.comm_ctrl[scs_pkg::CTRL_TX_EN_BIT];

    // ======================================================================
    // bus data lanes: registers live in the low half-word
    assign wr_word = {q.w_strb[1] ? q.w_data[15:8] : 8'h00, q.w_strb[0] ? q.w_data[7:0] : 8'h00};

    // read mux, unmapped addresses answer slave error
    always_comb begin
        rd_word = 16'h0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            scs_pkg::ADDR_CLOCK_GATE: rd_word = {8'h00, q.clock_gate};
            scs_pkg::ADDR_PRESCALER: rd_word = q.prescaler;
            scs_pkg::ADDR_MODE: rd_word = q.mode;
            scs_pkg::ADDR_COMM_CTRL: rd_word = q.comm_ctrl;
            scs_pkg::ADDR_DATA_DIV: rd_word = q.data_div;
            scs_pkg::ADDR_TX_DATA: rd_word = {7'h00, q.tx_buf_full, q.tx_buf};
            scs_pkg::ADDR_IRQ_STATUS: rd_word = {14'h0000, q.irq_status};
            scs_pkg::ADDR_IRQ_MASK: rd_word = {14'h0000, q.irq_mask};
            default: rd_ok = 1'b0;
        endcase
    end

    // ======================================================================
    // next state of bus slave, registers and transmitter
    always_comb begin
        d = q;
        chan_event = 2'b00;
        d.sck_sync = {q.sck_sync[1:0], serial_clock_pin};
        // write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = scs_pkg::AXI_OKAY;
            unique case (q.aw_addr)
                scs_pkg::ADDR_CLOCK_GATE: begin
                    if (q.w_strb[0]) begin
                        d.clock_gate = q.w_data[7:0];
                    end
                end
                scs_pkg::ADDR_PRESCALER: d.prescaler = {8'h00, wr_word[7:0]};
                scs_pkg::ADDR_MODE: begin
                    // a prohibited protocol code keeps the old protocol and flags it
                    if (wr_word[scs_pkg::MODE_PROTO_LSB +: 2] == scs_pkg::PROTO_PROHIBITED) begin
                        d.mode = {wr_word[15:3], q.mode[2:1], wr_word[0]};
                        d.irq_status[scs_pkg::IRQ_PROHIB_BIT] = 1'b1;
                    end else begin
                        d.mode = wr_word;
                    end
                end
                scs_pkg::ADDR_COMM_CTRL: d.comm_ctrl = wr_word;
                scs_pkg::ADDR_DATA_DIV: d.data_div = wr_word;
                scs_pkg::ADDR_TX_DATA: begin
                    // a byte written while the buffer holds one is dropped
                    if (!q.tx_buf_full && q.w_strb[0]) begin
                        d.tx_buf = q.w_data[7:0];
                        d.tx_buf_full = 1'b1;
                    end
                end
                scs_pkg::ADDR_IRQ_STATUS: d.irq_status = d.irq_status & ~wr_word[1:0];
                scs_pkg::ADDR_IRQ_MASK: d.irq_mask = wr_word[1:0];
                default: d.bresp = scs_pkg::AXI_SLVERR;
            endcase
        end
        // read answer
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rdata = {16'h0000, rd_word};
            d.rresp = rd_ok ? scs_pkg::AXI_OKAY : scs_pkg::AXI_SLVERR;
        end
        // transfer clock divider runs on the operation clock tick
        // compare by >= so a smaller divider written mid-count does not wrap through 255
        if (unit_run && op_tick) begin
            d.baud_cnt = (q.baud_cnt >= div_last) ? 8'h00 : q.baud_cnt + 8'h01;
        end
        // transmitter: 8 data bits lsb first, one stop bit, uart only
        if (channel_transfer_clock_tick) begin
            unique case (q.tx_state)
                scs_pkg::TX_IDLE: begin
                    if (q.tx_buf_full && tx_enabled && proto == scs_pkg::PROTO_UART) begin
                        d.tx_shift = q.tx_buf;
                        d.tx_buf_full = 1'b0;
                        d.txd = 1'b0;
                        d.tx_state = scs_pkg::TX_START;
                        chan_event[1] = 1'b1;
                    end
                end
                scs_pkg::TX_START: begin
                    d.txd = q.tx_shift[0];
                    d.tx_shift = {1'b0, q.tx_shift[7:1]};
                    d.bit_cnt = 4'h0;
                    d.tx_state = scs_pkg::TX_DATA;
                end
                scs_pkg::TX_DATA: begin
                    if (q.bit_cnt == scs_pkg::DATA_BITS_LAST) begin
                        d.txd = 1'b1;
                        d.tx_state = scs_pkg::TX_STOP;
                    end else begin
                        d.txd = q.tx_shift[0];
                        d.tx_shift = {1'b0, q.tx_shift[7:1]};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end
                end
                scs_pkg::TX_STOP: begin
                    d.tx_state = scs_pkg::TX_IDLE;
                    chan_event[0] = 1'b1;
                end
            endcase
        end
        // chosen source sets the sticky bit; set wins over a same-cycle clear
        if (q.mode[scs_pkg::MODE_IRQ_SRC_BIT] ? chan_event[1] : chan_event[0]) begin
            d.irq_status[scs_pkg::IRQ_CHAN_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            q <= '0;
            q.clock_gate <= scs_pkg::GATE_RESET;
            q.prescaler <= scs_pkg::PRS_RESET;
            q.mode <= scs_pkg::MODE_RESET;
            q.comm_ctrl <= scs_pkg::CTRL_RESET;
            q.data_div <= scs_pkg::DIV_RESET;
            q.tx_state <= scs_pkg::TX_IDLE;
            q.txd <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ======================================================================
    // outputs
    assign s_axi_awready = !q.aw_have;
    assign s_axi_wready = !q.w_have;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign txd = q.txd;
    assign irq = |(q.irq_status & q.irq_mask);

endmodule : scs_channel

// file: scs_channel_asserts.sv
// bus handshake and line checks on the serial channel top ports
// assumes binding onto scs_channel, one clock domain with srst
`timescale 1ns/10ps
module scs_channel_asserts (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic txd,
    input wire logic irq
);
    // ======================================================================
    // sequences and properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_answer;
        s_wr_taken |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_rd_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    property p_rd_unmapped;
        s_rd_taken and (s_axi_araddr > 8'h1C) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    // a taken address or data word is held, so the channel refuses the next one
    property p_w_block;
        (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) and (s_axi_wvalid && s_axi_wready |=> !s_axi_wready);
    endproperty
    // shortest bit is two cycles, so a start bit never lasts one
    property p_start_bit;
        $fell(txd) |=> !txd;
    endproperty
    property p_reset;
        disable iff (1'b0) srst |=> txd && !irq && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response late");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read data late");
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not refused");
    a_ar_block: assert property (p_ar_block)
        else $error("read address taken during data");
    a_w_block: assert property (p_w_block)
        else $error("write address or data taken twice");
    a_start_bit: assert property (p_start_bit)
        else $error("start bit too short");
    a_reset: assert property (p_reset)
        else $error("outputs not at reset level");
endmodule : scs_channel_asserts
bind scs_channel scs_channel_asserts i_chk (.core_clk(core_clk), .srst(srst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txd(txd), .irq(irq));

// file: scs_uart_peer.sv
// far-end receiver on the transmit line plus an external pin clock
// assumes bit_cycles gives the bit period in core_clk cycles
`timescale 1ns/10ps
module scs_uart_peer (
    input wire logic core_clk,
    input wire logic txd,
    input wire logic pin_run,
    input int bit_cycles,
    output logic serial_clock_pin,
    output logic [7:0] rx_byte,
    output logic frame_err,
    output int rx_count
);
    logic [2:0] pin_cnt = 3'h0;
    initial begin
        serial_clock_pin = 1'b0;
        rx_byte = 8'h00;
        frame_err = 1'b0;
        rx_count = 0;
    end
    // ======================================================================
    // pin clock of 16 cycles, held low outside use
    always @(posedge core_clk) begin
        pin_cnt <= pin_run ? pin_cnt + 3'h1 : 3'h0;
        serial_clock_pin <= pin_run && (pin_cnt == 3'h7) ? ~serial_clock_pin : serial_clock_pin && pin_run;
    end
    // mid-bit sampling, lsb first, one stop bit
    always begin
        @(negedge txd);
        repeat (bit_cycles / 2) @(posedge core_clk);
        if (txd) frame_err = 1'b1;
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cycles) @(posedge core_clk);
            rx_byte[i] = txd;
        end
        repeat (bit_cycles) @(posedge core_clk);
        if (!txd) frame_err = 1'b1;
        rx_count++;
    end
endmodule : scs_uart_peer

// file: scs_channel_tb_top.sv
// self-checking bench: registers, interrupt, frames, gating and directions
// assumes scs_channel, scs_uart_peer and the bound checker
`timescale 1ns/10ps
module scs_channel_tb_top;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, pin_run = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic awready, wready, bvalid, arready, rvalid, pin, txd, irq, frame_err;
    logic [7:0] rx_byte;
    logic [31:0] rdata_q;
    int n_fail = 0, compares = 0, bit_cycles = 2, rx_count;
    int exp_q[$];
    logic [31:0] rst_tbl[9] = '{32'h0, 32'h0, 32'h20, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [7:0] reg_a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
    logic [31:0] reg_m[6] = '{32'hFF, 32'hFF, 32'hFFFF, 32'hC000, 32'hFE00, 32'h3};
    always #10 core_clk = ~core_clk;
    scs_channel i_dut (.core_clk(core_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_clock_pin(pin),
        .txd(txd), .irq(irq));
    scs_uart_peer i_peer (.core_clk(core_clk), .txd(txd), .pin_run(pin_run), .bit_cycles(bit_cycles),
        .serial_clock_pin(pin), .rx_byte(rx_byte), .frame_err(frame_err), .rx_count(rx_count));
    // ======================================================================
    // checking and closing
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic give_up(input string what);
        chk(what, 32'h0, 32'h1);
        final_report();
    endtask : give_up
    // bus master: valid held until its ready edge, bready until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic ad, wd;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge core_clk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'h7};
        do begin
            @(posedge core_clk);
            if (awready && !ad) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !wd) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
            if (++n > 200) give_up("write timeout");
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            if (++n > 200) give_up("read timeout");
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
    task automatic rx_check();
        int n0, n;
        n0 = rx_count;
        n = 0;
        while (rx_count == n0) begin
            @(posedge core_clk);
            if (++n > 12 * bit_cycles + 300) give_up("frame timeout");
        end
        chk("rx byte", 32'(rx_byte), 32'(exp_q.pop_front()));
        chk("frame", 32'(frame_err), 32'h0);
    endtask : rx_check
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int ka, kb, dv, n;
        void'($urandom(32'h0DC4));
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        // reset values, then one unmapped read and write
        for (int i = 0; i < 9; i++) begin
            rd(8'(i * 4), d, r);
            chk("reset value", d, rst_tbl[i]);
            chk("read resp", 32'(r), i < 8 ? 32'h0 : 32'h2);
        end
        wr(8'h24, 32'h5, r);
        chk("write resp", 32'(r), 32'h2);
        // masked read-back, protocol kept legal
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            if (i == 2) d[2:1] = 2'h1;
            wr(reg_a[i], d, r);
            rd(reg_a[i], rdata_q, r);
            chk("reg readback", rdata_q & reg_m[i], d & reg_m[i]);
        end
        // prohibited code keeps the old protocol and raises a flag
        wr(8'h08, 32'h26, r);
        rd(8'h08, d, r);
        chk("mode", d, 32'h22);
        wr(8'h1C, 32'h0, r);
        chk("irq masked", 32'(irq), 32'h0);
        wr(8'h1C, 32'h2, r);
        chk("irq unmasked", 32'(irq), 32'h1);
        wr(8'h18, 32'h3, r);
        rd(8'h18, d, r);
        chk("status cleared", d | 32'(irq), 32'h0);
        $display("done registers");
        // one frame per clock path and irq source
        for (int c = 0; c < 3; c++) begin
            {ka, kb, dv} = {$urandom % 3, $urandom % 3, $urandom % 4};
            pin_run <= (c == 2);
            bit_cycles = c == 2 ? 16 : (1 << (c == 1 ? kb : ka)) * (2 * dv + 2);
            wr(8'h00, 32'h4, r);
            wr(8'h04, 32'(kb * 16 + ka), r);
            wr(8'h10, 32'(dv * 512), r);
            wr(8'h1C, 32'h1, r);
            wr(8'h0C, 32'h8000, r);
            wr(8'h08, 32'h22 | (c == 1 ? 32'h8001 : 32'h0) | (c == 2 ? 32'h4000 : 32'h0), r);
            exp_q.push_back($urandom % 256);
            wr(8'h14, 32'(exp_q[$]), r);
            rx_check();
            chk("irq at stop", 32'(irq), 32'(c == 1));
            for (n = 0; !irq && n < 4 * bit_cycles + 50; n++) @(posedge core_clk);
            // let the stop bit finish before the clocks are reprogrammed
            repeat (bit_cycles) @(posedge core_clk);
            rd(8'h18, d, r);
            chk("event", d, 32'h1);
            wr(8'h18, 32'h1, r);
            chk("irq clear", 32'(irq), 32'h0);
            $display("done frame %0d", c);
        end
        // gate off, then direction and protocol codes that must not send
        pin_run <= 1'b0;
        wr(8'h08, 32'h22, r);
        bit_cycles = (1 << ka) * (2 * dv + 2);
        wr(8'h00, 32'h0, r);
        exp_q.push_back($urandom % 256);
        wr(8'h14, 32'(exp_q[$]), r);
        for (int g = 0; g < 4; g++) begin
            if (g == 3) wr(8'h08, 32'h24, r);
            if (g > 0) wr(8'h0C, g == 1 ? 32'h0 : (g == 2 ? 32'h4000 : 32'hC000), r);
            if (g > 0) wr(8'h00, 32'h4, r);
            d = 32'h1;
            repeat (300) @(posedge core_clk) d = d & 32'(txd & !irq);
            chk("line idle", d, 32'h1);
            rd(8'h14, d, r);
            chk("buffer full", d & 32'h100, 32'h100);
        end
        wr(8'h08, 32'h22, r);
        rx_check();
        $display("done gating");
        final_report();
    end
endmodule : scs_channel_tb_top
